// ===== two_wire_slave_16bit_addr_tb.sv
`default_nettype none
module two_wire_slave_16bit_addr_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tws_pkg::*;
  logic        clk;
  logic        rst;
  logic        go;
  logic        rd;
  logic        sel;
  logic [6:0]  dev;
  logic [15:0] addr;
  logic [7:0]  wdat;
  logic        ready;
  logic        done;
  logic        nack;
  logic [7:0]  rdat;
  logic        stb;
  logic [15:0] waddr;
  logic [7:0]  wdata;
  logic        busy;
  logic [36:0] sh;
  int          starts = 0;
  int          stops = 0;
  int          stb_cnt = 0;
  int          mismatches = 0;
  int          num_checks = 0;

  tws_if link ();
  // Small quarter keeps the run short; still above the slave's sync lag
  tws_master #(.QTR(8)) tws_master_i (.i_sys_clk(clk), .i_rst(rst), .bus(link),
    .i_go(go), .i_rd(rd), .i_dev(dev), .i_reg_addr(addr), .i_wr_data(wdat),
    .o_ready(ready), .o_done(done), .o_nack(nack), .o_rd_data(rdat));
  tws_slave tws_slave_i (.i_sys_clk(clk), .i_rst(rst), .bus(link), .i_addr_sel(sel),
    .o_wr_stb(stb), .o_wr_addr(waddr), .o_wr_data(wdata), .o_busy(busy));
  tws_monitor tws_monitor_i (.i_sys_clk(clk), .i_rst(rst), .scl(link.scl),
    .m_sda_o(link.m_sda_o), .m_sda_oe_n(link.m_sda_oe_n), .s_sda_o(link.s_sda_o),
    .s_sda_oe_n(link.s_sda_oe_n), .sda(link.sda));

  always #12.5 clk = ~clk;
  // Bits as seen on the wire at each scl rise; the stop's own rise lands in bit 0
  always @(posedge link.scl) sh <= {sh[35:0], link.sda};
  always @(negedge link.sda) if (link.scl === 1'b1) starts++;
  always @(posedge link.sda) if (link.scl === 1'b1) stops++;
  always @(posedge clk) if (stb === 1'b1) stb_cnt++;

  task automatic close_out();
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic r, input logic [6:0] d, input logic [15:0] a,
                      input logic [7:0] w);
    int n;
    n = 0;
    @(posedge clk);
    rd <= r;
    dev <= d;
    addr <= a;
    wdat <= w;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    chk(16'(ready), 16'h0);
    while (done !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    chk(16'(done), 16'h1);
    chk(16'(ready), 16'h1);
    repeat (2) @(posedge clk);
  endtask

  task automatic wr_ok(input logic [6:0] d, input logic [15:0] a, input logic [7:0] w);
    int s0;
    int p0;
    int k0;
    s0 = starts;
    p0 = stops;
    k0 = stb_cnt;
    xfer(DIR_WR, d, a, w);
    chk(16'(nack), 16'h0);
    chk(16'(stb_cnt - k0), 16'h1);
    chk(waddr, a);
    chk(16'(wdata), 16'(w));
    chk(16'(sh[36:28]), {7'h0, d, DIR_WR, 1'b0});
    chk(16'(sh[27:19]), {7'h0, a[15:8], 1'b0});
    chk(16'(sh[18:10]), {7'h0, a[7:0], 1'b0});
    chk(16'(sh[9:1]), {7'h0, w, 1'b0});
    chk(16'(sh[0]), 16'h0);
    chk(16'(starts - s0), 16'h1);
    chk(16'(stops - p0), 16'h1);
    chk(16'({link.scl, link.sda, busy}), 16'h6);
  endtask

  task automatic rd_ok(input logic [6:0] d, input logic [15:0] a, input logic [7:0] e);
    int s0;
    int p0;
    s0 = starts;
    p0 = stops;
    xfer(DIR_RD, d, a, 8'h00);
    chk(16'(nack), 16'h0);
    chk(16'(rdat), 16'(e));
    chk(16'(sh[18:10]), {7'h0, d, DIR_RD, 1'b0});
    chk(16'(sh[9:1]), {7'h0, e, 1'b1});
    chk(16'(starts - s0), 16'h2);
    chk(16'(stops - p0), 16'h1);
  endtask

  task automatic nak(input logic [6:0] d);
    int k0;
    k0 = stb_cnt;
    xfer(DIR_WR, d, 16'h0055, 8'hEE);
    chk(16'(nack), 16'h1);
    chk(16'(stb_cnt - k0), 16'h0);
    chk(16'(sh[9:1]), {7'h0, d, DIR_WR, 1'b1});
    chk(16'(busy), 16'h0);
  endtask

  task automatic t_sel_low();
    @(posedge clk);
    sel <= 1'b0;
    wr_ok(ADDR_LO, 16'h12A5, 8'h3C);
    rd_ok(ADDR_LO, 16'h12A5, 8'h3C);
    nak(ADDR_HI);
  endtask

  task automatic t_sel_high();
    @(posedge clk);
    sel <= 1'b1;
    wr_ok(ADDR_HI, 16'hFFFF, 8'hA5);
    rd_ok(ADDR_HI, 16'hFFFF, 8'hA5);
    nak(ADDR_LO);
  endtask

  // Back-to-back neighbours, then an older byte must survive
  task automatic t_neighbours();
    @(posedge clk);
    sel <= 1'b0;
    wr_ok(ADDR_LO, 16'h0040, 8'h81);
    wr_ok(ADDR_LO, 16'h0041, 8'h7E);
    rd_ok(ADDR_LO, 16'h0040, 8'h81);
    rd_ok(ADDR_LO, 16'h0041, 8'h7E);
    rd_ok(ADDR_LO, 16'h12A5, 8'h3C);
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    go = 1'b0;
    rd = 1'b0;
    sel = 1'b0;
    dev = 7'h00;
    addr = 16'h0000;
    wdat = 8'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_sel_low();
    t_sel_high();
    t_neighbours();
    close_out();
  end

  // Eleven transfers need well under half of this span
  initial begin
    #1000000;
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire

// ===== tws_dummy_placeholder_never.sv
`default_nettype none
`default_nettype wire

// ===== tws_if.sv
`default_nettype none
interface tws_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  logic sda;

  // Wired-AND of both open-drain drivers; released line reads high
  assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);

  modport master (output scl, output m_sda_o, output m_sda_oe_n, input sda);
  modport slave  (input scl, input sda, output s_sda_o, output s_sda_oe_n);
endinterface
`default_nettype wire

// ===== tws_master.sv
`default_nettype none
module tws_master #(
  parameter int QTR = tws_pkg::QTR_CYC
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  tws_if.master            bus,
  input  wire logic        i_go,
  input  wire logic        i_rd,
  input  wire logic [6:0]  i_dev,
  input  wire logic [15:0] i_reg_addr,
  input  wire logic [7:0]  i_wr_data,
  output logic             o_ready,
  output logic             o_done,
  output logic             o_nack,
  output logic      [7:0]  o_rd_data
);
  import tws_pkg::*;

  localparam int            TW       = (QTR > 1) ? $clog2(QTR) : 1;
  localparam logic [TW-1:0] QTR_LAST = TW'(QTR - 1);

  typedef struct packed {
    tws_mst_t    st;
    logic [TW-1:0] tick;
    logic [1:0]  q;
    logic [3:0]  bitn;
    logic [2:0]  idx;
    logic [7:0]  sh;
    logic        rd;
    logic [6:0]  dev;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        scl;
    logic        oe_n;
    logic [7:0]  rdata;
    logic        done;
    logic        nack;
    logic        ready;
  } tws_mstr_t;

  tws_mstr_t r_reg;
  tws_mstr_t r_next;
  logic      sda_s;
  logic      qt;
  logic      rx;
  logic      last;

  tws_sync #(
    .W (1)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   (bus.sda),
    .o_sync    (sda_s),
    .o_prev    ()
  );

  function automatic logic [7:0] pick(input tws_mstr_t s, input logic [2:0] i);
    logic [7:0] b;
    b = {s.dev, DIR_WR};
    if (i == IX_AHI) begin
      b = s.addr[15:8];
    end else if (i == IX_ALO) begin
      b = s.addr[7:0];
    end else if (i == IX_THIRD) begin
      b = s.rd ? {s.dev, DIR_RD} : s.wdata;
    end
    return b;
  endfunction

  assign qt   = (r_reg.tick == QTR_LAST);
  assign rx   = r_reg.rd && (r_reg.idx == IX_RDATA);
  assign last = r_reg.rd ? (r_reg.idx == IX_RDATA) : (r_reg.idx == IX_THIRD);

  // Each bit is four quarter periods: set data, clock high, sample, clock low
  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    r_next.tick = qt ? '0 : r_reg.tick + 1'b1;
    if (qt && r_reg.st != TWS_M_IDLE) begin
      r_next.q = r_reg.q + 2'h1;
    end
    case (r_reg.st)
      TWS_M_IDLE: begin
        r_next.scl   = 1'b1;
        r_next.oe_n  = 1'b1;
        r_next.ready = 1'b1;
        if (i_go) begin
          r_next.st    = TWS_M_START;
          r_next.ready = 1'b0;
          r_next.rd    = i_rd;
          r_next.dev   = i_dev;
          r_next.addr  = i_reg_addr;
          r_next.wdata = i_wr_data;
          r_next.idx   = IX_DEV;
          r_next.nack  = 1'b0;
          r_next.q     = 2'h0;
          r_next.tick  = '0;
        end
      end
      TWS_M_START: begin
        if (qt) begin
          case (r_reg.q)
            2'h0: r_next.oe_n = 1'b1;
            2'h1: r_next.scl = 1'b1;
            2'h2: r_next.oe_n = 1'b0;
            default: begin
              r_next.scl  = 1'b0;
              r_next.st   = TWS_M_BIT;
              r_next.bitn = 4'h0;
              r_next.sh   = pick(r_reg, r_reg.idx);
            end
          endcase
        end
      end
      TWS_M_BIT: begin
        if (qt) begin
          case (r_reg.q)
            2'h0: begin
              // Ack slot: released for slave ack, or no-ack after the read byte
              if (r_reg.bitn == ACK_SLOT || rx) begin
                r_next.oe_n = 1'b1;
              end else begin
                r_next.oe_n = r_reg.sh[7];
              end
            end
            2'h1: r_next.scl = 1'b1;
            2'h2: begin
              if (r_reg.bitn != ACK_SLOT) begin
                r_next.sh = {r_reg.sh[6:0], sda_s};
              end else if (!rx && sda_s) begin
                r_next.nack = 1'b1;
              end
            end
            default: begin
              r_next.scl = 1'b0;
              if (r_reg.bitn != ACK_SLOT) begin
                r_next.bitn = r_reg.bitn + 4'h1;
              end else begin
                r_next.bitn = 4'h0;
                if (rx) begin
                  r_next.rdata = r_reg.sh;
                end
                if (r_reg.nack || last) begin
                  r_next.st = TWS_M_STOP;
                end else if (r_reg.rd && r_reg.idx == IX_ALO) begin
                  r_next.st  = TWS_M_START;
                  r_next.idx = IX_THIRD;
                end else begin
                  r_next.idx = r_reg.idx + 3'h1;
                  r_next.sh  = pick(r_reg, r_reg.idx + 3'h1);
                end
              end
            end
          endcase
        end
      end
      default: begin
        if (qt) begin
          case (r_reg.q)
            2'h0: r_next.oe_n = 1'b0;
            2'h1: r_next.scl = 1'b1;
            2'h2: r_next.oe_n = 1'b1;
            default: begin
              r_next.st    = TWS_M_IDLE;
              r_next.done  = 1'b1;
              r_next.ready = 1'b1;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      r_reg <= '{st: TWS_M_IDLE, scl: 1'b1, oe_n: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign bus.scl        = r_reg.scl;
  assign bus.m_sda_o    = 1'b0;
  assign bus.m_sda_oe_n = r_reg.oe_n;
  assign o_ready        = r_reg.ready;
  assign o_done         = r_reg.done;
  assign o_nack         = r_reg.nack;
  assign o_rd_data      = r_reg.rdata;
endmodule
`default_nettype wire

// ===== tws_monitor.sv
`default_nettype none
module tws_monitor (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic scl,
  input wire logic m_sda_o,
  input wire logic m_sda_oe_n,
  input wire logic s_sda_o,
  input wire logic s_sda_oe_n,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       scl_q;
  logic       sda_q;
  logic       in_frame;
  logic [3:0] pulls;
  wire logic  start = scl && scl_q && sda_q && !sda;
  wire logic  stop  = scl && scl_q && !sda_q && sda;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // Raw line edges; the slave lags these by its synchroniser
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      in_frame <= 1'b0;
      pulls    <= 4'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        in_frame <= 1'b1;
      end else if (stop) begin
        in_frame <= 1'b0;
      end
      if (scl && !scl_q) begin
        pulls <= s_sda_oe_n ? 4'h0 : pulls + 4'h1;
      end
    end
  end

  chk_change_scl_low: assert property (
    $changed(s_sda_oe_n) |-> !scl && !$past(scl, 2)) else $error("slave moved sda near scl high");
  chk_no_slave_start: assert property (
    scl && $past(scl) |-> !$fell(s_sda_oe_n)) else $error("slave pulled sda with scl high");
  chk_no_slave_stop: assert property (
    scl && $past(scl) |-> !$rose(s_sda_oe_n)) else $error("slave released sda with scl high");
  chk_idle_released: assert property (
    !in_frame |-> s_sda_oe_n) else $error("slave drives idle bus");
  chk_idle_scl_high: assert property (
    !in_frame |-> scl) else $error("scl low on idle bus");
  chk_start_holds: assert property (
    start |-> scl [*4]) else $error("scl dropped right at start");
  chk_stop_quiet: assert property (
    stop |=> s_sda_oe_n [*8]) else $error("slave drives after stop");
  chk_pull_bounded: assert property (
    pulls <= 4'h9) else $error("slave pulled sda over nine bits");
  chk_open_drain: assert property (
    !s_sda_oe_n |-> s_sda_o == 1'b0) else $error("slave drives sda high");
  // Both may pull low for a few cycles after a fall; never while scl is high
  chk_master_yields: assert property (
    scl && !s_sda_oe_n |-> m_sda_oe_n && m_sda_o == 1'b0) else $error("master drives sda in slave slot");
endmodule
`default_nettype wire

// ===== tws_pkg.sv
`default_nettype none
package tws_pkg;
  localparam int          CLK_NS    = 25;
  localparam int          SCL_NS    = 10000;
  localparam int          QTR_CYC   = SCL_NS / (4 * CLK_NS);
  localparam logic [6:0]  ADDR_LO   = 7'h48;
  localparam logic [6:0]  ADDR_HI   = 7'h45;
  localparam logic        DIR_WR    = 1'b0;
  localparam logic        DIR_RD    = 1'b1;
  localparam logic [2:0]  LAST_BIT  = 3'h7;
  localparam logic [3:0]  ACK_SLOT  = 4'h8;
  localparam logic [1:0]  PH_AHI    = 2'h1;
  localparam logic [1:0]  PH_ALO    = 2'h2;
  localparam logic [1:0]  PH_DATA   = 2'h3;
  localparam logic [2:0]  IX_DEV    = 3'h0;
  localparam logic [2:0]  IX_AHI    = 3'h1;
  localparam logic [2:0]  IX_ALO    = 3'h2;
  localparam logic [2:0]  IX_THIRD  = 3'h3;
  localparam logic [2:0]  IX_RDATA  = 3'h4;

  typedef enum logic [2:0] {
    TWS_S_IDLE = 3'h0,
    TWS_S_DEV  = 3'h1,
    TWS_S_ACK  = 3'h3,
    TWS_S_RX   = 3'h2,
    TWS_S_TX   = 3'h6,
    TWS_S_MACK = 3'h7
  } tws_sst_t;

  typedef enum logic [1:0] {
    TWS_M_IDLE  = 2'h0,
    TWS_M_START = 2'h1,
    TWS_M_BIT   = 2'h3,
    TWS_M_STOP  = 2'h2
  } tws_mst_t;
endpackage
`default_nettype wire

// ===== tws_slave.sv
// Function
// - Slave only; master clocks, data shared line
// - Sixteen-bit register address after slave byte
// - Idle both high; start takes, stop frees
// - Only master makes start and stop
// - Start is data falling while clock high
// - Stop is data rising while clock high
// - Repeated start begins a new transfer
// - Eight bits MSB first, then ack bit
// - Data changes only while clock low
// - First byte: address bits 7-1, direction bit 0
// - Select pin picks 90/91 or 8A/8B
// - Transmitter releases, receiver pulls low to ack
// - Line high after byte means no-ack
// - Ack only own address, else silent
// - Write: address high, low, data, all acked
// - Address increments after each written byte
// - Master ends write with stop or restart
// - Random read: address write, restart, read
// - Read increments address, master no-ack ends
// - Read without address uses kept address
// - Sequential reads run until master no-ack
// - Master ends writes with stop
`default_nettype none
module tws_slave #(
  parameter int MEM_AW = 8
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  tws_if.slave             bus,
  input  wire logic        i_addr_sel,
  output logic             o_wr_stb,
  output logic      [15:0] o_wr_addr,
  output logic      [7:0]  o_wr_data,
  output logic             o_busy
);
  import tws_pkg::*;

  typedef struct packed {
    tws_sst_t    st;
    logic [7:0]  sh;
    logic [2:0]  cnt;
    logic        full;
    logic        seen;
    logic        nack;
    logic        rd;
    logic [1:0]  phase;
    logic [15:0] ptr;
    logic        oe_n;
    logic        wr_stb;
    logic [15:0] wr_addr;
    logic [7:0]  wr_data;
    logic        busy;
  } tws_slv_t;

  tws_slv_t   r_reg;
  tws_slv_t   r_next;
  logic [2:0] cur;
  logic [2:0] prv;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic [6:0] my_addr;
  logic [7:0] rdat;
  logic       mem_we;
  logic [7:0] mem [2**MEM_AW];

  // Bit 2 clock, bit 1 data, bit 0 address select
  tws_sync #(
    .W (3)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   ({bus.scl, bus.sda, i_addr_sel}),
    .o_sync    (cur),
    .o_prev    (prv)
  );

  assign rise    = cur[2] & ~prv[2];
  assign fall    = ~cur[2] & prv[2];
  assign start   = cur[2] & prv[2] & prv[1] & ~cur[1];
  assign stop    = cur[2] & prv[2] & ~prv[1] & cur[1];
  assign my_addr = cur[0] ? ADDR_HI : ADDR_LO;
  assign rdat    = mem[r_reg.ptr[MEM_AW-1:0]];

  always_comb begin
    r_next        = r_reg;
    r_next.wr_stb = 1'b0;
    mem_we        = 1'b0;
    if (stop) begin
      r_next.st   = TWS_S_IDLE;
      r_next.oe_n = 1'b1;
    end else if (start) begin
      r_next.st   = TWS_S_DEV;
      r_next.cnt  = 3'h0;
      r_next.full = 1'b0;
      r_next.oe_n = 1'b1;
    end else begin
      case (r_reg.st)
        TWS_S_DEV, TWS_S_RX: begin
          // Sample on the rising clock edge, act on the falling one
          if (rise) begin
            r_next.sh   = {r_reg.sh[6:0], cur[1]};
            r_next.cnt  = r_reg.cnt + 3'h1;
            r_next.full = (r_reg.cnt == LAST_BIT);
          end else if (fall && r_reg.full) begin
            r_next.full = 1'b0;
            r_next.seen = 1'b0;
            r_next.st   = TWS_S_ACK;
            r_next.oe_n = 1'b0;
            if (r_reg.st == TWS_S_DEV) begin
              if (r_reg.sh[7:1] == my_addr) begin
                r_next.rd    = (r_reg.sh[0] == DIR_RD);
                r_next.phase = PH_AHI;
              end else begin
                r_next.st   = TWS_S_IDLE;
                r_next.oe_n = 1'b1;
              end
            end else if (r_reg.phase == PH_AHI) begin
              r_next.ptr[15:8] = r_reg.sh;
              r_next.phase     = PH_ALO;
            end else if (r_reg.phase == PH_ALO) begin
              r_next.ptr[7:0] = r_reg.sh;
              r_next.phase    = PH_DATA;
            end else begin
              mem_we         = 1'b1;
              r_next.wr_stb  = 1'b1;
              r_next.wr_addr = r_reg.ptr;
              r_next.wr_data = r_reg.sh;
              r_next.ptr     = r_reg.ptr + 16'h1;
            end
          end
        end
        TWS_S_ACK: begin
          if (rise) begin
            r_next.seen = 1'b1;
          end else if (fall && r_reg.seen) begin
            r_next.cnt  = 3'h0;
            r_next.full = 1'b0;
            if (r_reg.rd) begin
              // Kept pointer serves reads with no address phase
              r_next.st   = TWS_S_TX;
              r_next.sh   = rdat;
              r_next.oe_n = rdat[7];
              r_next.ptr  = r_reg.ptr + 16'h1;
            end else begin
              r_next.st   = TWS_S_RX;
              r_next.oe_n = 1'b1;
            end
          end
        end
        TWS_S_TX: begin
          if (fall) begin
            if (r_reg.cnt == LAST_BIT) begin
              r_next.st   = TWS_S_MACK;
              r_next.seen = 1'b0;
              r_next.oe_n = 1'b1;
            end else begin
              r_next.sh   = {r_reg.sh[6:0], 1'b0};
              r_next.oe_n = r_reg.sh[6];
              r_next.cnt  = r_reg.cnt + 3'h1;
            end
          end
        end
        TWS_S_MACK: begin
          if (rise) begin
            r_next.seen = 1'b1;
            r_next.nack = cur[1];
          end else if (fall && r_reg.seen) begin
            if (r_reg.nack) begin
              r_next.st = TWS_S_IDLE;
            end else begin
              r_next.st   = TWS_S_TX;
              r_next.cnt  = 3'h0;
              r_next.sh   = rdat;
              r_next.oe_n = rdat[7];
              r_next.ptr  = r_reg.ptr + 16'h1;
            end
          end
        end
        default: begin
          r_next.oe_n = 1'b1;
        end
      endcase
    end
    r_next.busy = (r_next.st != TWS_S_IDLE);
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      r_reg <= '{st: TWS_S_IDLE, oe_n: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // Storage has no reset; content is undefined until written
  always_ff @(posedge i_sys_clk) begin
    if (mem_we) begin
      mem[r_reg.ptr[MEM_AW-1:0]] <= r_reg.sh;
    end
  end

  assign bus.s_sda_o    = 1'b0;
  assign bus.s_sda_oe_n = r_reg.oe_n;
  assign o_wr_stb       = r_reg.wr_stb;
  assign o_wr_addr      = r_reg.wr_addr;
  assign o_wr_data      = r_reg.wr_data;
  assign o_busy         = r_reg.busy;
endmodule
`default_nettype wire

// ===== tws_sync.sv
`default_nettype none
module tws_sync #(
  parameter int W = 1
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync,
  output logic      [W-1:0] o_prev
);
  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
  } tws_sync_t;

  tws_sync_t r_reg;
  tws_sync_t r_next;

  // Lines idle high, so reset to one avoids a false edge at release
  always_comb begin
    r_next     = r_reg;
    r_next.ff1 = i_async;
    r_next.ff2 = r_reg.ff1;
    r_next.ff3 = r_reg.ff2;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      r_reg <= '{ff1: '1, ff2: '1, ff3: '1};
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_sync = r_reg.ff2;
  assign o_prev = r_reg.ff3;
endmodule
`default_nettype wire
